// ### verilog/pmc_pkg.sv
// constants and types for the status word format and mask control block
package pmc_pkg;
    // status word bit positions, bit 0 is the leftmost
    localparam int PSW_W          = 64;
    localparam int PSW_FMT_BIT    = 12;
    localparam int PSW_TRACE_BIT  = 1;
    localparam int PSW_XLATE_BIT  = 5;
    localparam int PSW_IO_BIT     = 6;
    localparam int PSW_EXT_BIT    = 7;
    localparam int PSW_BC_CODE_LO = 16;
    localparam int PSW_BC_ILC_LO  = 32;
    localparam int PSW_BC_CC_LO   = 34;
    localparam int PSW_BC_PM_LO   = 36;
    localparam int PSW_EC_CC_LO   = 18;
    localparam int PSW_EC_PM_LO   = 20;
    localparam int BC_IO_CHAN_BITS = 6;
    // control register bits
    localparam int CR0_SSM_SUPP_BIT = 1;
    localparam int CR0_EXT_LO       = 16;
    localparam int CR0_TIMER_BIT    = 24;
    localparam int EXT_TIMER_SRC    = CR0_TIMER_BIT - CR0_EXT_LO;
    localparam logic [3:0] CR_IDX_EXT = 4'h0;
    localparam logic [3:0] CR_IDX_IO  = 4'h2;
    // widths
    localparam int IO_CHANS  = 8;
    localparam int EXT_SRCS  = 16;
    localparam int TRACE_EVS = 4;
    // permanently assigned storage addresses
    localparam logic [11:0] CODE_POST_ADDR  = 12'h08c;
    localparam logic [11:0] TRACE_POST_ADDR = 12'h096;
    // values after reset
    localparam logic [0:63] PSW_RESET = 64'h0;
    localparam logic [0:31] CR_RESET  = 32'h0;
    localparam logic        SSM_SUPP_INSTALLED = 1'b1;
    typedef enum logic [3:0] {
        PMC_OP_SET    = 4'h1,
        PMC_OP_ANDSTO = 4'h2,
        PMC_OP_ORSTO  = 4'h4,
        PMC_OP_NONE   = 4'h8
    } pmc_mask_op_e;
endpackage : pmc_pkg

// ### verilog/pmc_mode_mask_ctrl.sv
// status word format selection and system mask control
`timescale 1ns/1ns
// How it works
// - status word bit 12 selects basic (0) or extended (1) layout.
// - any status word load may switch format.
// - extended format keeps selective masks in control registers.
// - extended format posts length and interruption codes to fixed storage.
// - extended format keeps condition code and program mask at 18-23.
// - extended bit 1 is master enable for program event tracing.
// - traced event raises interruption and posts address and code.
// - extended bit 5 enables virtual address translation.
// - I/O and assigned storage addresses are never translated.
// - channel indirect addressing is allowed in both formats, unmasked.
// - extended bit 6 gates I/O with per-channel masks of register two.
// - extended bit 7 gates external with per-source masks of register zero.
// - store-then-AND saves mask, then clears bits that are zero in the immediate.
// - store-then-OR saves mask, then sets selected bits.
// - register zero bit 1 suppresses set-mask, raising special-operation.
// - trace mask zero or basic format blocks all event interruptions.
// - timer interruption needs mask bit 7 and register zero bit 24.
module pmc_mode_mask_ctrl
    import pmc_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic                 sys_rst,
    input  wire logic                 pswLoadValid,
    input  wire logic [0:63]          pswLoadWord,
    input  wire logic                 ccPmWrite,
    input  wire logic [1:0]           ccIn,
    input  wire logic [3:0]           pmIn,
    input  wire logic                 intTakeValid,
    input  wire logic [15:0]          intCode,
    input  wire logic [1:0]           intIlc,
    input  wire logic                 crWrite,
    input  wire logic [3:0]           crIndex,
    input  wire logic [0:31]          crData,
    input  wire logic                 maskOpValid,
    input  wire pmc_mask_op_e         maskOp,
    input  wire logic [0:7]           maskImm,
    input  wire logic [23:0]          maskAddr,
    input  wire logic [0:3]           traceEvent,
    input  wire logic [0:3]           traceControl,
    input  wire logic [23:0]          instrAddr,
    input  wire logic                 addrReqValid,
    input  wire logic                 addrIsIo,
    input  wire logic                 addrIsAssigned,
    input  wire logic                 cidaReq,
    input  wire logic [0:7]           ioPending,
    input  wire logic [0:15]          extPending,
    output logic                      ecMode,
    output logic [0:7]                sysMask,
    output logic [0:63]               pswWord,
    output logic                      oldPswValid,
    output logic [0:63]               oldPswWord,
    output logic                      codePostValid,
    output logic [11:0]               codePostAddr,
    output logic [31:0]               codePostData,
    output logic                      maskStoreValid,
    output logic [23:0]               maskStoreAddr,
    output logic [0:7]                maskStoreData,
    output logic                      maskDone,
    output logic                      specialOpExc,
    output logic                      traceIntReq,
    output logic                      tracePostValid,
    output logic [11:0]               tracePostAddr,
    output logic [0:31]               tracePostData,
    output logic                      addrTranslate,
    output logic                      addrDone,
    output logic                      cidaGrant,
    output logic [0:7]                ioIntReq,
    output logic [0:15]               extIntReq
);
    logic [0:63] psw_q;
    logic [0:31] crExt_q;
    logic [0:31] crIo_q;
    logic        ssmSuppressed;
    logic        maskOpGo;
    logic [0:3]  traceHits;

    // basic format: channels 0-5 own bits, rest share bit 6
    function automatic logic ioMaskOf(input logic [0:63] w, input int ch);
        if (w[PSW_FMT_BIT])
            return w[PSW_IO_BIT];
        else if (ch < BC_IO_CHAN_BITS)
            return w[ch];
        else
            return w[PSW_IO_BIT];
    endfunction : ioMaskOf

    assign ssmSuppressed = SSM_SUPP_INSTALLED
                           && crExt_q[CR0_SSM_SUPP_BIT];
    assign maskOpGo  = maskOpValid && !pswLoadValid;
    assign traceHits = traceEvent & traceControl;

    // status word: load wins over mask ops, mask ops over cc/pm update
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            psw_q <= PSW_RESET;
        end else if (pswLoadValid) begin
            psw_q <= pswLoadWord;
        end else if (maskOpGo) begin
            case (maskOp)
                PMC_OP_SET: begin
                    if (!ssmSuppressed)
                        psw_q[0:7] <= maskImm;
                end
                PMC_OP_ANDSTO: psw_q[0:7] <= psw_q[0:7] & maskImm;
                PMC_OP_ORSTO:  psw_q[0:7] <= psw_q[0:7] | maskImm;
                default: psw_q <= psw_q;
            endcase
        end else if (ccPmWrite) begin
            if (psw_q[PSW_FMT_BIT]) begin
                psw_q[PSW_EC_CC_LO +: 2] <= ccIn;
                psw_q[PSW_EC_PM_LO +: 4] <= pmIn;
            end else begin
                psw_q[PSW_BC_CC_LO +: 2] <= ccIn;
                psw_q[PSW_BC_PM_LO +: 4] <= pmIn;
            end
        end
    end

    // selective masks live in control registers; basic format also masks channels 0-5 with word bits 0-5
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            crExt_q <= CR_RESET;
            crIo_q  <= CR_RESET;
        end else if (crWrite) begin
            if (crIndex == CR_IDX_EXT)
                crExt_q <= crData;
            if (crIndex == CR_IDX_IO)
                crIo_q <= crData;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ecMode  <= 1'b0;
            sysMask <= 8'h00;
            pswWord <= PSW_RESET;
        end else begin
            ecMode  <= psw_q[PSW_FMT_BIT];
            sysMask <= psw_q[0:7];
            pswWord <= psw_q;
        end
    end

    // old word on interruption; extended format moves codes out of it
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            oldPswValid   <= 1'b0;
            oldPswWord    <= PSW_RESET;
            codePostValid <= 1'b0;
            codePostAddr  <= CODE_POST_ADDR;
            codePostData  <= 32'h0;
        end else begin
            oldPswValid   <= intTakeValid;
            codePostValid <= intTakeValid && psw_q[PSW_FMT_BIT];
            codePostAddr  <= CODE_POST_ADDR;
            codePostData  <= {14'h0, intIlc, intCode};
            if (intTakeValid) begin
                oldPswWord <= psw_q;
                if (!psw_q[PSW_FMT_BIT]) begin
                    oldPswWord[PSW_BC_CODE_LO +: 16] <= intCode;
                    oldPswWord[PSW_BC_ILC_LO +: 2]   <= intIlc;
                end
            end
        end
    end

    // the old mask is saved and updated in one step, so no window exists
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            maskStoreValid <= 1'b0;
            maskStoreAddr  <= 24'h0;
            maskStoreData  <= 8'h00;
            maskDone       <= 1'b0;
            specialOpExc   <= 1'b0;
        end else begin
            maskStoreValid <= maskOpGo && (maskOp == PMC_OP_ANDSTO
                              || maskOp == PMC_OP_ORSTO);
            maskStoreAddr  <= maskAddr;
            maskStoreData  <= psw_q[0:7];
            maskDone       <= maskOpGo;
            specialOpExc   <= maskOpGo && maskOp == PMC_OP_SET
                              && ssmSuppressed;
        end
    end

    // event tracing only in extended format with its master bit set
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            traceIntReq    <= 1'b0;
            tracePostValid <= 1'b0;
            tracePostAddr  <= TRACE_POST_ADDR;
            tracePostData  <= 32'h0;
        end else begin
            traceIntReq    <= psw_q[PSW_FMT_BIT] && psw_q[PSW_TRACE_BIT]
                              && |traceHits;
            tracePostValid <= psw_q[PSW_FMT_BIT] && psw_q[PSW_TRACE_BIT]
                              && |traceHits;
            tracePostAddr  <= TRACE_POST_ADDR;
            tracePostData  <= {traceHits, 4'h0, instrAddr};
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            addrTranslate <= 1'b0;
            addrDone      <= 1'b0;
            cidaGrant     <= 1'b0;
        end else begin
            addrTranslate <= addrReqValid && psw_q[PSW_FMT_BIT]
                             && psw_q[PSW_XLATE_BIT]
                             && !addrIsIo && !addrIsAssigned;
            addrDone      <= addrReqValid;
            cidaGrant     <= cidaReq;
        end
    end

    // master bit in the word (basic-format channels 0-5 use their own word bits), selective bit in the control register
    genvar gi;
    generate
        for (gi = 0; gi < IO_CHANS; gi++) begin : g_io
            always_ff @(posedge core_clk) begin
                if (sys_rst)
                    ioIntReq[gi] <= 1'b0;
                else
                    ioIntReq[gi] <= ioPending[gi] && ioMaskOf(psw_q, gi)
                                    && crIo_q[gi];
            end
        end
        for (gi = 0; gi < EXT_SRCS; gi++) begin : g_ext
            always_ff @(posedge core_clk) begin
                if (sys_rst)
                    extIntReq[gi] <= 1'b0;
                else
                    extIntReq[gi] <= extPending[gi] && psw_q[PSW_EXT_BIT]
                                     && crExt_q[CR0_EXT_LO + gi];
            end
        end
    endgenerate

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    property p_format;
        ecMode == pswWord[PSW_FMT_BIT];
    endproperty
    a_format: assert property (p_format)
        else $error("format flag differs from word bit 12");

    property p_switch;
        pswLoadValid |=> ##1 ecMode == $past(pswLoadWord[PSW_FMT_BIT], 2);
    endproperty
    a_switch: assert property (p_switch)
        else $error("format did not follow loaded word");

    sequence s_andOp;
        maskOpValid && !pswLoadValid && maskOp == PMC_OP_ANDSTO;
    endsequence
    sequence s_orOp;
        maskOpValid && !pswLoadValid && maskOp == PMC_OP_ORSTO;
    endsequence
    property p_andMask;
        s_andOp |=> maskStoreValid && maskStoreData == $past(psw_q[0:7])
            && psw_q[0:7] == ($past(psw_q[0:7]) & $past(maskImm));
    endproperty
    a_andMask: assert property (p_andMask)
        else $error("store-then-and result wrong");

    property p_orMask;
        s_orOp |=> maskStoreValid && maskDone
            && maskStoreAddr == $past(maskAddr)
            && psw_q[0:7] == ($past(psw_q[0:7]) | $past(maskImm));
    endproperty
    a_orMask: assert property (p_orMask)
        else $error("store-then-or result wrong");

    property p_ssmSupp;
        maskOpValid && !pswLoadValid && maskOp == PMC_OP_SET
            && crExt_q[CR0_SSM_SUPP_BIT]
            |=> specialOpExc && $stable(psw_q[0:7]);
    endproperty
    a_ssmSupp: assert property (p_ssmSupp)
        else $error("set-mask not suppressed");

    property p_traceGate;
        traceIntReq |-> $past(psw_q[PSW_FMT_BIT] && psw_q[PSW_TRACE_BIT]);
    endproperty
    a_traceGate: assert property (p_traceGate)
        else $error("trace interruption while tracing disabled");

    property p_tracePost;
        traceIntReq |-> tracePostValid && tracePostAddr == TRACE_POST_ADDR
            && tracePostData[8:31] == $past(instrAddr);
    endproperty
    a_tracePost: assert property (p_tracePost)
        else $error("trace post missing");

    property p_xlate;
        addrTranslate |-> $past(psw_q[PSW_FMT_BIT] && psw_q[PSW_XLATE_BIT]
            && !addrIsIo && !addrIsAssigned);
    endproperty
    a_xlate: assert property (p_xlate)
        else $error("translation of exempt address");

    property p_timer;
        extIntReq[EXT_TIMER_SRC] |->
            $past(psw_q[PSW_EXT_BIT] && crExt_q[CR0_TIMER_BIT]);
    endproperty
    a_timer: assert property (p_timer)
        else $error("timer interruption while masked");

    property p_ioGate;
        |ioIntReq |-> $past(!psw_q[PSW_FMT_BIT] || psw_q[PSW_IO_BIT]);
    endproperty
    a_ioGate: assert property (p_ioGate)
        else $error("io interruption with master mask off");

    property p_ecPost;
        intTakeValid && psw_q[PSW_FMT_BIT] |=> codePostValid && oldPswValid;
    endproperty
    a_ecPost: assert property (p_ecPost)
        else $error("codes not posted in extended format");

    property p_cida;
        cidaReq |=> cidaGrant;
    endproperty
    a_cida: assert property (p_cida)
        else $error("indirect addressing refused");
endmodule : pmc_mode_mask_ctrl

// ### sim/pmc_mode_mask_ctrl_test.sv
// randomised self-checking bench for the format and mask control block
`timescale 1ns/1ns
`define CHK(got, exp) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) begin \
            errors++; \
            $display("unexpected at %0t got %h expected %h", \
                     $time, got, exp); \
        end \
    end
module pmc_mode_mask_ctrl_test
    import pmc_pkg::*;
;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic pswLoadValid = 1'b0, ccPmWrite = 1'b0, intTakeValid = 1'b0;
    logic [0:63] pswLoadWord = 64'h0;
    logic [1:0] ccIn = 2'h0, intIlc = 2'h0;
    logic [3:0] pmIn = 4'h0, crIndex = 4'h0;
    logic [15:0] intCode = 16'h0;
    logic crWrite = 1'b0, maskOpValid = 1'b0;
    logic [0:31] crData = 32'h0;
    pmc_mask_op_e maskOp = PMC_OP_NONE;
    logic [0:7] maskImm = 8'h0;
    logic [23:0] maskAddr = 24'h0, instrAddr = 24'h0;
    logic [0:3] traceEvent = 4'h0, traceControl = 4'h0;
    logic addrReqValid = 1'b0, addrIsIo = 1'b0, addrIsAssigned = 1'b0;
    logic cidaReq = 1'b0;
    logic [0:7] ioPending = 8'h0;
    logic [0:15] extPending = 16'h0;
    logic ecMode, oldPswValid, codePostValid, maskStoreValid, maskDone;
    logic specialOpExc, traceIntReq, tracePostValid, addrTranslate;
    logic addrDone, cidaGrant;
    logic [0:7] sysMask, maskStoreData, ioIntReq;
    logic [0:63] pswWord, oldPswWord;
    logic [11:0] codePostAddr, tracePostAddr;
    logic [31:0] codePostData;
    logic [23:0] maskStoreAddr;
    logic [0:31] tracePostData;
    logic [0:15] extIntReq;
    int errors = 0;
    int tests_run = 0;

    pmc_mode_mask_ctrl DUT (
        .core_clk, .sys_rst, .pswLoadValid, .pswLoadWord, .ccPmWrite,
        .ccIn, .pmIn, .intTakeValid, .intCode, .intIlc, .crWrite,
        .crIndex, .crData, .maskOpValid, .maskOp, .maskImm, .maskAddr,
        .traceEvent, .traceControl, .instrAddr, .addrReqValid, .addrIsIo,
        .addrIsAssigned, .cidaReq, .ioPending, .extPending, .ecMode,
        .sysMask, .pswWord, .oldPswValid, .oldPswWord, .codePostValid,
        .codePostAddr, .codePostData, .maskStoreValid, .maskStoreAddr,
        .maskStoreData, .maskDone, .specialOpExc, .traceIntReq,
        .tracePostValid, .tracePostAddr, .tracePostData, .addrTranslate,
        .addrDone, .cidaGrant, .ioIntReq, .extIntReq
    );

    always #4 core_clk = ~core_clk;

    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask : tick

    task automatic report_and_stop();
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    function automatic logic [0:7] exp_mask(input pmc_mask_op_e op,
            input logic [0:7] m, input logic [0:7] imm, input logic supp);
        case (op)
            PMC_OP_ANDSTO: return m & imm;
            PMC_OP_ORSTO: return m | imm;
            PMC_OP_SET: return supp ? m : imm;
            default: return m;
        endcase
    endfunction : exp_mask

    task automatic load_psw(input logic [0:63] w);
        pswLoadWord = w;
        pswLoadValid = 1'b1;
        tick(1);
        pswLoadValid = 1'b0;
        tick(2);
        `CHK(ecMode, w[PSW_FMT_BIT])
        `CHK(pswWord, w)
        `CHK(sysMask, w[0:7])
    endtask : load_psw

    task automatic write_cr(input logic [3:0] idx, input logic [0:31] d);
        crIndex = idx;
        crData = d;
        crWrite = 1'b1;
        tick(1);
        crWrite = 1'b0;
        tick(2);
    endtask : write_cr

    task automatic mask_op(input pmc_mask_op_e op, input logic supp);
        logic [0:7] old;
        logic st;
        old = sysMask;
        st = op inside {PMC_OP_ANDSTO, PMC_OP_ORSTO};
        maskOp = op;
        maskImm = 8'($urandom);
        maskAddr = 24'($urandom);
        maskOpValid = 1'b1;
        tick(1);
        // pulses stand one cycle only, so look before the next edge
        `CHK(maskDone, 1'b1)
        `CHK(maskStoreValid, st)
        if (st) `CHK(maskStoreData, old)
        if (st) `CHK(maskStoreAddr, maskAddr)
        `CHK(specialOpExc, op == PMC_OP_SET && supp)
        maskOpValid = 1'b0;
        tick(1);
        `CHK(sysMask, exp_mask(op, old, maskImm, supp))
    endtask : mask_op

    task automatic trace_chk(input logic [0:3] ev, input logic en);
        logic [0:3] hits;
        hits = ev & traceControl & {4{en}};
        traceEvent = ev;
        tick(1);
        `CHK(traceIntReq, |hits)
        `CHK(tracePostValid, |hits)
        if (|hits) `CHK(tracePostData, {hits, 4'h0, instrAddr})
        traceEvent = 4'h0;
        tick(1);
    endtask : trace_chk

    task automatic addr_chk(input logic en);
        addrIsIo = 1'($urandom);
        addrIsAssigned = 1'($urandom);
        addrReqValid = 1'b1;
        cidaReq = 1'b1;
        tick(1);
        `CHK(addrDone, 1'b1)
        `CHK(addrTranslate, en & !addrIsIo & !addrIsAssigned)
        `CHK(cidaGrant, 1'b1)
        addrReqValid = 1'b0;
        cidaReq = 1'b0;
        tick(1);
    endtask : addr_chk

    task automatic int_chk(input logic ec);
        intCode = 16'($urandom);
        intIlc = 2'($urandom);
        intTakeValid = 1'b1;
        tick(1);
        `CHK(oldPswValid, 1'b1)
        `CHK(codePostValid, ec)
        if (ec) `CHK(codePostData, {14'h0, intIlc, intCode})
        else `CHK(oldPswWord[16:33], {intCode, intIlc})
        intTakeValid = 1'b0;
        ccIn = 2'($urandom);
        pmIn = 4'($urandom);
        ccPmWrite = 1'b1;
        tick(1);
        ccPmWrite = 1'b0;
        tick(2);
        if (ec) `CHK(pswWord[18:23], {ccIn, pmIn})
        else `CHK(pswWord[34:39], {ccIn, pmIn})
    endtask : int_chk

    // generous bound: each loop pass needs only about 22 cycles
    initial begin
        #(8 * 5000);
        errors++;
        report_and_stop();
    end

    initial begin
        logic [0:63] w;
        logic [0:31] c0, c2;
        void'($urandom(32'hf4889287));
        tick(8);
        sys_rst = 1'b0;
        `CHK(ecMode, 1'b0)
        `CHK(codePostAddr, CODE_POST_ADDR)
        `CHK(tracePostAddr, TRACE_POST_ADDR)
        for (int i = 0; i < 16; i++) begin
            w = {$urandom, $urandom};
            w[PSW_FMT_BIT] = 1'b1;
            w[PSW_IO_BIT] = i[0];
            w[PSW_EXT_BIT] = i[1];
            w[PSW_TRACE_BIT] = i[2];
            load_psw(w);
            c0 = $urandom;
            c0[CR0_SSM_SUPP_BIT] = i[3];
            c2 = $urandom;
            write_cr(CR_IDX_EXT, c0);
            write_cr(CR_IDX_IO, c2);
            ioPending = 8'($urandom);
            extPending = 16'($urandom);
            tick(3);
            `CHK(ioIntReq, ioPending & c2[0:7] & {8{w[6]}})
            `CHK(extIntReq, extPending & c0[16:31] & {16{w[7]}})
            `CHK(extIntReq[8], extPending[8] & c0[24] & w[7])
            traceControl = 4'($urandom);
            instrAddr = 24'($urandom);
            trace_chk(4'($urandom), w[PSW_TRACE_BIT]);
            addr_chk(w[PSW_XLATE_BIT]);
            int_chk(1'b1);
            // one-hot op codes: set, and, or, none in turn
            mask_op(pmc_mask_op_e'(4'h1 << (i % 4)), c0[1]);
        end
        w = {$urandom, $urandom};
        w[PSW_FMT_BIT] = 1'b0;
        w[PSW_TRACE_BIT] = 1'b1;
        w[PSW_XLATE_BIT] = 1'b1;
        load_psw(w);
        // basic format: channels 0-5 own mask bits, 6 and 7 share bit 6
        `CHK(ioIntReq, ioPending & c2[0:7] & {w[0:5], {2{w[6]}}})
        traceControl = 4'hf;
        trace_chk(4'hf, 1'b0);
        addr_chk(1'b0);
        int_chk(1'b0);
        report_and_stop();
    end
endmodule : pmc_mode_mask_ctrl_test
